/* rtl/t2ub_top.sv */
`timescale 1ns/1ns
module t2ub_top
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins and neighbour timer
    input wire logic timer2_count_pin,
    input wire logic external_trigger_pin,
    input wire logic timer1_overflow,
    // results
    output logic timer2_irq_q,
    output logic rx_bit_clock_q,
    output logic tx_bit_clock_q,
    output logic timer2_overflow_q
);
    logic [7:0] serial_control_q;
    logic [7:0] serial_buffer_q;
    logic [7:0] baud_reload_value_q;
    logic [7:0] baud_control_q;
    logic [7:0] slave_address_q;
    logic [7:0] slave_address_mask_q;
    logic [7:0] timer2_control_q;
    logic [15:0] t2_count_q;
    logic [15:0] t2_reload_q;
    logic [2:0] aux_control_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic count_fall;
    logic trig_fall;
    logic brg_tick;

    t2ub_pin_sync u_count_sync
    (
        .clock(clock),
        .rst_n(rst_n),
        .pin(timer2_count_pin),
        .fall_q(count_fall)
    );
    t2ub_pin_sync u_trig_sync
    (
        .clock(clock),
        .rst_n(rst_n),
        .pin(external_trigger_pin),
        .fall_q(trig_fall)
    );
    t2ub_baud_gen u_brg
    (
        .clock(clock),
        .rst_n(rst_n),
        .run(baud_control_q[t2ub_pkg::BC_RUN]),
        .speed_fast(baud_control_q[t2ub_pkg::BC_SPEED]),
        .doubler(aux_control_q[t2ub_pkg::AUX_DOUBLER]),
        .reload(baud_reload_value_q),
        .tick_q(brg_tick)
    );

    // apb decode; single access cycle, no wait states
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire hit_sc = (paddr == t2ub_pkg::OFS_SERIAL_CONTROL);
    wire hit_sb = (paddr == t2ub_pkg::OFS_SERIAL_BUFFER);
    wire hit_brl = (paddr == t2ub_pkg::OFS_BAUD_RELOAD);
    wire hit_bc = (paddr == t2ub_pkg::OFS_BAUD_CONTROL);
    wire hit_sa = (paddr == t2ub_pkg::OFS_SLAVE_ADDRESS);
    wire hit_sm = (paddr == t2ub_pkg::OFS_SLAVE_MASK);
    wire hit_t2c = (paddr == t2ub_pkg::OFS_TIMER2_CONTROL);
    wire hit_cnt = (paddr == t2ub_pkg::OFS_TIMER2_COUNT);
    wire hit_rld = (paddr == t2ub_pkg::OFS_TIMER2_RELOAD);
    wire hit_aux = (paddr == t2ub_pkg::OFS_AUX_CONTROL);
    wire hit_st = (paddr == t2ub_pkg::OFS_AUX_STATUS);
    wire hit_any = hit_sc | hit_sb | hit_brl | hit_bc | hit_sa | hit_sm | hit_t2c | hit_cnt | hit_rld | hit_aux
        | hit_st;

    // timer 2 control decode
    wire t2_rclk = timer2_control_q[t2ub_pkg::T2C_RCLK];
    wire t2_transmit_clock_select = timer2_control_q[t2ub_pkg::T2C_TRANSMIT_CLOCK_SELECT];
    wire baud_use = t2_rclk | t2_transmit_clock_select;
    wire exen = timer2_control_q[t2ub_pkg::T2C_EXEN];
    // R9 serial use forces reload
    wire capture_mode = timer2_control_q[t2ub_pkg::T2C_CPRL] && !baud_use;
    // R7 R8 count source select
    wire inc_src = timer2_control_q[t2ub_pkg::T2C_CT] ? count_fall : 1'b1;
    // R17 run gate
    wire inc = timer2_control_q[t2ub_pkg::T2C_RUN] && inc_src;
    wire t2_ovf = inc && (t2_count_q == 16'hFFFF);
    // R6 trigger edge only when enabled
    wire ext_event = exen && trig_fall;
    // capture mode lets the count wrap to zero on overflow instead of reloading
    wire do_reload = !capture_mode && (t2_ovf || ext_event);
    wire do_capture = ext_event && capture_mode;
    // R1 overflow flag only without serial use
    wire set_ovf = t2_ovf && !baud_use;
    // R2 external flag on capture or reload
    wire set_ext = ext_event;

    // field writes keep every bit individually addressable
    wire [7:0] t2c_wr = pwdata[7:0];
    wire [7:0] t2c_d = {
        (wr && hit_t2c ? t2c_wr[t2ub_pkg::T2C_OVF] : timer2_control_q[t2ub_pkg::T2C_OVF]) | set_ovf,
        (wr && hit_t2c ? t2c_wr[t2ub_pkg::T2C_EXT] : timer2_control_q[t2ub_pkg::T2C_EXT]) | set_ext,
        wr && hit_t2c ? t2c_wr[5:0] : timer2_control_q[5:0]
    };

    // R3 R4 interrupt request
    wire irq_d = aux_control_q[t2ub_pkg::AUX_T2IE] && (timer2_control_q[t2ub_pkg::T2C_OVF]
        || (timer2_control_q[t2ub_pkg::T2C_EXT] && !aux_control_q[t2ub_pkg::AUX_UP_DOWN_COUNT_ENABLE]));

    // serial mode decode
    wire [1:0] smode = {serial_control_q[t2ub_pkg::SC_MODE_HI], serial_control_q[t2ub_pkg::SC_MODE_LO]};
    wire var_mode = smode[0];
    wire mode0 = (smode == 2'b00);
    wire brg_rx = baud_control_q[t2ub_pkg::BC_RX_BRG];
    wire brg_tx = baud_control_q[t2ub_pkg::BC_TX_BRG];
    // R5 receive clock source
    wire rx_timer = t2_rclk ? t2_ovf : timer1_overflow;
    // R16 transmit clock source
    wire tx_timer = t2_transmit_clock_select ? t2_ovf : timer1_overflow;
    // R10 baud generator in modes 1 3 and 0
    wire mode0_brg = mode0 && baud_control_q[t2ub_pkg::BC_MODE0] && brg_tick;
    wire rx_d = var_mode ? (brg_rx ? brg_tick : rx_timer) : mode0_brg;
    wire tx_d = var_mode ? (brg_tx ? brg_tick : tx_timer) : mode0_brg;

    // read mux
    wire [31:0] rd_mux =
        hit_sc ? {24'h000000, serial_control_q} :
        hit_sb ? {24'h000000, serial_buffer_q} :
        hit_brl ? {24'h000000, baud_reload_value_q} :
        hit_bc ? {24'h000000, baud_control_q} :
        hit_sa ? {24'h000000, slave_address_q} :
        hit_sm ? {24'h000000, slave_address_mask_q} :
        hit_t2c ? {24'h000000, timer2_control_q} :
        hit_cnt ? {16'h0000, t2_count_q} :
        hit_rld ? {16'h0000, t2_reload_q} :
        hit_aux ? {29'h0000000, aux_control_q} :
        hit_st ? {29'h0000000, timer2_irq_q, rx_bit_clock_q, tx_bit_clock_q} :
        32'h00000000;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            // R11 R13 zero reset
            serial_control_q <= t2ub_pkg::RST_BYTE;
            baud_reload_value_q <= t2ub_pkg::RST_BYTE;
            baud_control_q <= t2ub_pkg::RST_BYTE;
            slave_address_q <= t2ub_pkg::RST_BYTE;
            slave_address_mask_q <= t2ub_pkg::RST_BYTE;
            timer2_control_q <= t2ub_pkg::RST_BYTE;
            t2_count_q <= t2ub_pkg::RST_WORD;
            t2_reload_q <= t2ub_pkg::RST_WORD;
            aux_control_q <= 3'h0;
            timer2_irq_q <= 1'b0;
            rx_bit_clock_q <= 1'b0;
            tx_bit_clock_q <= 1'b0;
            timer2_overflow_q <= 1'b0;
        end
        else
        begin
            // R11 bitwise writes
            if (wr && hit_sc)
                serial_control_q <= pwdata[7:0];
            if (wr && hit_brl)
                baud_reload_value_q <= pwdata[7:0];
            if (wr && hit_bc)
                baud_control_q <= {3'h0, pwdata[4:0]};
            if (wr && hit_sa)
                slave_address_q <= pwdata[7:0];
            if (wr && hit_sm)
                slave_address_mask_q <= pwdata[7:0];
            if (wr && hit_aux)
                aux_control_q <= pwdata[2:0];
            timer2_control_q <= t2c_d;
            if (wr && hit_rld)
                t2_reload_q <= pwdata[15:0];
            else if (do_capture)
                t2_reload_q <= t2_count_q;
            // R9 reload on overflow or trigger
            if (wr && hit_cnt)
                t2_count_q <= pwdata[15:0];
            else if (do_reload)
                t2_count_q <= t2_reload_q;
            else if (inc)
                t2_count_q <= t2_count_q + 16'h0001;
            timer2_irq_q <= irq_d;
            rx_bit_clock_q <= rx_d;
            tx_bit_clock_q <= tx_d;
            timer2_overflow_q <= t2_ovf;
        end
    end

    // R12 buffer has no reset value
    always_ff @(posedge clock)
    begin
        if (wr && hit_sb)
            serial_buffer_q <= pwdata[7:0];
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= psel && !penable;
            pslverr_q <= psel && !penable && !hit_any;
            prdata_q <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
        end
    end
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
endmodule // t2ub_top

/* rtl/t2ub_pkg.sv */
// Contract
// R1: timer2_overflow_flag is set on Timer 2 overflow only while both serial clock selects are 0, and holds until software clears it.
// R2: with external_event_enable set, each capture or reload caused by a trigger-pin falling edge sets timer2_external_flag, cleared by software.
// R3: a set timer2_external_flag requests the Timer 2 interrupt whenever that interrupt is enabled and up_down_count_enable is 0.
// R4: while up_down_count_enable is 1, timer2_external_flag raises no interrupt request.
// R5: in serial modes 1 and 3 the receive bit clock is Timer 2 overflow when the receive select is 1, else Timer 1 overflow.
// R6: with external_event_enable set a trigger-pin falling edge causes a capture or reload; with it clear such edges are ignored.
// R7: with counter_timer_select at 0 Timer 2 counts the peripheral clock.
// R8: with counter_timer_select at 1 Timer 2 counts falling edges of its count pin; software keeps it 0 in clock-out mode.
// R9: with capture_reload_select 0 the timer reloads on overflow and on enabled trigger edges; either serial clock select forces reload.
// R10: the internal baud generator clocks serial modes 1 and 3, and modes 0 too when baud_gen_mode0_select is set.
// R11: serial_control and timer2_control reset to zero and each bit is writable on its own.
// R12: serial_buffer content is undefined after reset.
// R13: slave_address, slave_address_mask and baud_reload_value reset to zero.
// R14: the baud generator overflow rate follows the reload value, baud_speed_mode and baud_doubler.
// R15: the baud generator runs only while baud_gen_run is 1.
// R16: in serial modes 1 and 3 the transmit bit clock is Timer 2 overflow when transmit_clock_select is 1, else Timer 1 overflow.
// R17: Timer 2 counts only while timer2_run_control is 1 and holds otherwise; an enabled trigger edge still reloads it while stopped in reload mode.
package t2ub_pkg;
    // register offsets are word indexes; the bus byte address is four times the index
    localparam logic [9:0] IDX_SERIAL_CONTROL = 10'h098;
    localparam logic [9:0] IDX_SERIAL_BUFFER = 10'h099;
    localparam logic [9:0] IDX_BAUD_RELOAD = 10'h09A;
    localparam logic [9:0] IDX_BAUD_CONTROL = 10'h09B;
    localparam logic [9:0] IDX_SLAVE_ADDRESS = 10'h0A9;
    localparam logic [9:0] IDX_SLAVE_MASK = 10'h0B9;
    localparam logic [9:0] IDX_TIMER2_CONTROL = 10'h0C8;
    localparam logic [9:0] IDX_TIMER2_COUNT = 10'h0CC;
    localparam logic [9:0] IDX_TIMER2_RELOAD = 10'h0CD;
    localparam logic [9:0] IDX_AUX_CONTROL = 10'h0CE;
    localparam logic [9:0] IDX_AUX_STATUS = 10'h0CF;
    localparam logic [11:0] OFS_SERIAL_CONTROL = {IDX_SERIAL_CONTROL, 2'h0};
    localparam logic [11:0] OFS_SERIAL_BUFFER = {IDX_SERIAL_BUFFER, 2'h0};
    localparam logic [11:0] OFS_BAUD_RELOAD = {IDX_BAUD_RELOAD, 2'h0};
    localparam logic [11:0] OFS_BAUD_CONTROL = {IDX_BAUD_CONTROL, 2'h0};
    localparam logic [11:0] OFS_SLAVE_ADDRESS = {IDX_SLAVE_ADDRESS, 2'h0};
    localparam logic [11:0] OFS_SLAVE_MASK = {IDX_SLAVE_MASK, 2'h0};
    localparam logic [11:0] OFS_TIMER2_CONTROL = {IDX_TIMER2_CONTROL, 2'h0};
    localparam logic [11:0] OFS_TIMER2_COUNT = {IDX_TIMER2_COUNT, 2'h0};
    localparam logic [11:0] OFS_TIMER2_RELOAD = {IDX_TIMER2_RELOAD, 2'h0};
    localparam logic [11:0] OFS_AUX_CONTROL = {IDX_AUX_CONTROL, 2'h0};
    localparam logic [11:0] OFS_AUX_STATUS = {IDX_AUX_STATUS, 2'h0};
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    // timer2_control fields
    localparam int T2C_OVF = 7;
    localparam int T2C_EXT = 6;
    localparam int T2C_RCLK = 5;
    localparam int T2C_TRANSMIT_CLOCK_SELECT = 4;
    localparam int T2C_EXEN = 3;
    localparam int T2C_RUN = 2;
    localparam int T2C_CT = 1;
    localparam int T2C_CPRL = 0;
    // serial_control mode bits
    localparam int SC_MODE_HI = 7;
    localparam int SC_MODE_LO = 6;
    // baud control fields
    localparam int BC_RUN = 4;
    localparam int BC_TX_BRG = 3;
    localparam int BC_RX_BRG = 2;
    localparam int BC_SPEED = 1;
    localparam int BC_MODE0 = 0;
    // aux control fields
    localparam int AUX_UP_DOWN_COUNT_ENABLE = 0;
    localparam int AUX_T2IE = 1;
    localparam int AUX_DOUBLER = 2;
    // slow speed mode divides the baud counter clock by this value plus one
    localparam logic [2:0] BRG_SLOW_DIV = 3'h5;
endpackage

/* rtl/t2ub_pin_sync.sv */
`timescale 1ns/1ns
module t2ub_pin_sync
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // pin and result
    input wire logic pin,
    output logic fall_q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;
    // change accepted once second and third stage agree
    wire agree = (s2_q == s3_q);
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            level_q <= 1'b1;
            fall_q <= 1'b0;
        end
        else
        begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (agree)
                level_q <= s3_q;
            fall_q <= agree && level_q && !s3_q;
        end
    end
endmodule // t2ub_pin_sync

/* rtl/t2ub_baud_gen.sv */
`timescale 1ns/1ns
module t2ub_baud_gen
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // control
    input wire logic run,
    input wire logic speed_fast,
    input wire logic doubler,
    input wire logic [7:0] reload,
    // result
    output logic tick_q
);
    logic [7:0] cnt_q;
    logic [2:0] pre_q;
    logic half_q;
    wire pre_done = speed_fast || (pre_q == t2ub_pkg::BRG_SLOW_DIV);
    wire ovf = pre_done && (cnt_q == 8'hFF);
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            cnt_q <= 8'h00;
            pre_q <= 3'h0;
            half_q <= 1'b0;
            tick_q <= 1'b0;
        end
        // R15 stop on run clear
        else if (!run)
        begin
            cnt_q <= reload;
            pre_q <= 3'h0;
            half_q <= 1'b0;
            tick_q <= 1'b0;
        end
        else
        begin
            // R14 rate from reload speed doubler
            pre_q <= pre_done ? 3'h0 : pre_q + 3'h1;
            if (pre_done)
                cnt_q <= ovf ? reload : cnt_q + 8'h01;
            if (ovf)
                half_q <= !half_q;
            tick_q <= ovf && (doubler || half_q);
        end
    end
endmodule // t2ub_baud_gen

/* testbench/t2ub_top_properties.sv */
`timescale 1ns/1ns
module t2ub_top_check
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // results
    input wire logic timer2_irq_q,
    input wire logic rx_bit_clock_q,
    input wire logic tx_bit_clock_q,
    input wire logic timer2_overflow_q
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    property p_setup; psel && !penable |=> pready; endproperty
    a_setup: assert property (p_setup) else $error("no answer after setup");
    property p_wait; psel && penable |-> pready; endproperty
    a_wait: assert property (p_wait) else $error("access without answer");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    property p_access; pready |-> psel && penable; endproperty
    a_access: assert property (p_access) else $error("ready outside access");
    property p_prior; pready |-> $past(psel) && !$past(penable); endproperty
    a_prior: assert property (p_prior) else $error("ready without setup");
    property p_idle; !pready |-> prdata == 32'h00000000; endproperty
    a_idle: assert property (p_idle) else $error("read data outside answer");
    property p_err; pslverr |-> pready && prdata == 32'h00000000; endproperty
    a_err: assert property (p_err) else $error("bad error answer");
    property p_reset;
        $rose(rst_n) |-> !(pready || timer2_irq_q || rx_bit_clock_q || tx_bit_clock_q || timer2_overflow_q);
    endproperty
    a_reset: assert property (p_reset) else $error("outputs busy after reset");
    c_read: cover property (pready && !pslverr);
    c_err: cover property (pslverr);
    c_ovf: cover property (timer2_overflow_q);
    c_irq: cover property (timer2_irq_q);
endmodule // t2ub_top_check

bind t2ub_top t2ub_top_check i_t2ub_top_check (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer2_irq_q(timer2_irq_q),
    .rx_bit_clock_q(rx_bit_clock_q), .tx_bit_clock_q(tx_bit_clock_q), .timer2_overflow_q(timer2_overflow_q));

/* testbench/t2ub_pin_model.sv */
`timescale 1ns/1ns
module t2ub_pin_model
#(
    parameter int LOW_CYCLES = 3,
    parameter int T1_DIV = 7
)
(
    // clock
    input wire logic clock,
    // bench requests
    input wire logic count_req,
    input wire logic trig_req,
    // pins and timer 1
    output logic timer2_count_pin,
    output logic external_trigger_pin,
    output logic timer1_overflow
);
    int cnt_low = 0;
    int trg_low = 0;
    int t1_div = 0;
    assign timer2_count_pin = cnt_low == 0;
    assign external_trigger_pin = trg_low == 0;
    assign timer1_overflow = t1_div == 0;
    // low phase outlasts the pin synchroniser; lines rest high like pulled-up port pins
    always @(posedge clock)
    begin
        cnt_low <= count_req ? LOW_CYCLES : (cnt_low > 0 ? cnt_low - 1 : 0);
        trg_low <= trig_req ? LOW_CYCLES : (trg_low > 0 ? trg_low - 1 : 0);
        t1_div <= t1_div == T1_DIV - 1 ? 0 : t1_div + 1;
    end
endmodule // t2ub_pin_model

/* testbench/t2ub_top_tb_top.sv */
`timescale 1ns/1ns
module t2ub_top_tb_top;
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, cnt_pin, trg_pin, t1_ovf, irq, rx_clk, tx_clk, ovf;
    logic cnt_req = 1'h0;
    logic trg_req = 1'h0;
    int mismatches = 0;
    int samples_checked = 0;
    int n_ov = 0, n_rx = 0, n_tx = 0, n_t1 = 0, d_ov, d_rx, d_tx, d_t1;
    always #5 clock = ~clock;
    always @(posedge clock)
    begin
        n_ov <= n_ov + (ovf === 1'h1);
        n_rx <= n_rx + (rx_clk === 1'h1);
        n_tx <= n_tx + (tx_clk === 1'h1);
        n_t1 <= n_t1 + (t1_ovf === 1'h1);
    end
    t2ub_top i_t2ub_top (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer2_count_pin(cnt_pin), .external_trigger_pin(trg_pin), .timer1_overflow(t1_ovf),
        .timer2_irq_q(irq), .rx_bit_clock_q(rx_clk), .tx_bit_clock_q(tx_clk), .timer2_overflow_q(ovf));
    t2ub_pin_model i_t2ub_pin_model (.clock(clock), .count_req(cnt_req), .trig_req(trg_req),
        .timer2_count_pin(cnt_pin), .external_trigger_pin(trg_pin), .timer1_overflow(t1_ovf));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        do @(posedge clock); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clock);
    endtask
    task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
        xfer(1'h0, a, 32'h0);
        chk(n, e, rd);
    endtask
    function automatic logic [31:0] near(int a, int b);
        return {31'h0, a >= b - 1 && a <= b + 1 && b > 2};
    endfunction
    task automatic measure;
        d_ov = n_ov;
        d_rx = n_rx;
        d_tx = n_tx;
        d_t1 = n_t1;
        repeat (160) @(posedge clock);
        d_ov = n_ov - d_ov;
        d_rx = n_rx - d_rx;
        d_tx = n_tx - d_tx;
        d_t1 = n_t1 - d_t1;
    endtask
    task automatic pulse(input logic trig);
        trg_req <= trig;
        cnt_req <= !trig;
        @(posedge clock);
        trg_req <= 1'h0;
        cnt_req <= 1'h0;
        repeat (10) @(posedge clock);
    endtask
    task automatic t_regs;
        logic [11:0] a [5] = '{t2ub_pkg::OFS_SERIAL_CONTROL, t2ub_pkg::OFS_BAUD_RELOAD, t2ub_pkg::OFS_SLAVE_ADDRESS,
            t2ub_pkg::OFS_SLAVE_MASK, t2ub_pkg::OFS_TIMER2_CONTROL};
        foreach (a[i]) rdchk("reset value", a[i], 32'h0);
        xfer(1'h0, t2ub_pkg::OFS_SERIAL_BUFFER, 32'h0);
        chk("buffer error", 32'h0, {31'h0, err});
        xfer(1'h0, 12'h000, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        xfer(1'h1, t2ub_pkg::OFS_SLAVE_MASK, 32'hA5);
        rdchk("mask", t2ub_pkg::OFS_SLAVE_MASK, 32'hA5);
    endtask
    task automatic t_ovf;
        logic [31:0] v;
        xfer(1'h1, t2ub_pkg::OFS_TIMER2_RELOAD, 32'hFFF0);
        xfer(1'h1, t2ub_pkg::OFS_TIMER2_COUNT, 32'hFFF0);
        xfer(1'h1, t2ub_pkg::OFS_TIMER2_CONTROL, 32'h04);
        repeat (40) @(posedge clock);
        rdchk("overflow flag", t2ub_pkg::OFS_TIMER2_CONTROL, 32'h84);
        xfer(1'h1, t2ub_pkg::OFS_TIMER2_CONTROL, 32'h80);
        xfer(1'h0, t2ub_pkg::OFS_TIMER2_COUNT, 32'h0);
        v = rd;
        repeat (20) @(posedge clock);
        rdchk("count held", t2ub_pkg::OFS_TIMER2_COUNT, v);
        rdchk("flag held", t2ub_pkg::OFS_TIMER2_CONTROL, 32'h80);
        xfer(1'h1, t2ub_pkg::OFS_TIMER2_CONTROL, 32'h00);
        rdchk("flag cleared", t2ub_pkg::OFS_TIMER2_CONTROL, 32'h00);
    endtask
    task automatic t_sel;
        logic [31:0] cfg [2] = '{32'h24, 32'h14};
        xfer(1'h1, t2ub_pkg::OFS_SERIAL_CONTROL, 32'h40);
        foreach (cfg[i])
        begin
            xfer(1'h1, t2ub_pkg::OFS_TIMER2_CONTROL, cfg[i]);
            measure();
            chk("reload period", 32'h1, near(d_ov, 10));
            chk("rx source", 32'h1, near(d_rx, i == 0 ? d_ov : d_t1));
            chk("tx source", 32'h1, near(d_tx, i == 1 ? d_ov : d_t1));
            rdchk("no overflow flag", t2ub_pkg::OFS_TIMER2_CONTROL, cfg[i]);
        end
    endtask
    task automatic t_ext;
        xfer(1'h1, t2ub_pkg::OFS_TIMER2_CONTROL, 32'h00);
        xfer(1'h1, t2ub_pkg::OFS_TIMER2_COUNT, 32'h0);
        xfer(1'h1, t2ub_pkg::OFS_AUX_CONTROL, 32'h2);
        xfer(1'h1, t2ub_pkg::OFS_TIMER2_CONTROL, 32'h0D);
        pulse(1'h1);
        rdchk("external flag", t2ub_pkg::OFS_TIMER2_CONTROL, 32'h4D);
        chk("external irq", 32'h1, {31'h0, irq});
        xfer(1'h0, t2ub_pkg::OFS_TIMER2_RELOAD, 32'h0);
        chk("capture taken", 32'h1, {31'h0, rd < 32'h100});
        xfer(1'h1, t2ub_pkg::OFS_AUX_CONTROL, 32'h3);
        repeat (2) @(posedge clock);
        chk("up/down mask", 32'h0, {31'h0, irq});
        xfer(1'h1, t2ub_pkg::OFS_TIMER2_CONTROL, 32'h05);
        pulse(1'h1);
        rdchk("edge ignored", t2ub_pkg::OFS_TIMER2_CONTROL, 32'h05);
    endtask
    task automatic t_cnt;
        // switch to pin counting before zeroing, so the timer stops counting clocks first
        xfer(1'h1, t2ub_pkg::OFS_TIMER2_CONTROL, 32'h06);
        xfer(1'h1, t2ub_pkg::OFS_TIMER2_COUNT, 32'h0);
        repeat (3) pulse(1'h0);
        rdchk("pin count", t2ub_pkg::OFS_TIMER2_COUNT, 32'h3);
        xfer(1'h1, t2ub_pkg::OFS_TIMER2_CONTROL, 32'h02);
        pulse(1'h0);
        rdchk("stopped count", t2ub_pkg::OFS_TIMER2_COUNT, 32'h3);
    endtask
    task automatic t_brg;
        int v;
        xfer(1'h1, t2ub_pkg::OFS_BAUD_RELOAD, 32'hFC);
        xfer(1'h1, t2ub_pkg::OFS_BAUD_CONTROL, 32'h1F);
        xfer(1'h1, t2ub_pkg::OFS_SERIAL_CONTROL, 32'h00);
        xfer(1'h1, t2ub_pkg::OFS_AUX_CONTROL, 32'h4);
        measure();
        v = d_rx;
        chk("mode 0 clocks", 32'h1, {31'h0, d_rx > 0 && d_tx == d_rx});
        xfer(1'h1, t2ub_pkg::OFS_AUX_CONTROL, 32'h0);
        measure();
        chk("doubler rate", 32'h1, {31'h0, d_rx > 0 && d_rx < v});
        xfer(1'h1, t2ub_pkg::OFS_BAUD_CONTROL, 32'h1E);
        measure();
        chk("mode 0 unselected", 32'h0, d_rx);
        xfer(1'h1, t2ub_pkg::OFS_SERIAL_CONTROL, 32'h40);
        xfer(1'h1, t2ub_pkg::OFS_BAUD_CONTROL, 32'h0E);
        measure();
        chk("generator stopped", 32'h0, d_tx);
    endtask
    task automatic t_rst;
        logic [11:0] a [6] = '{t2ub_pkg::OFS_SERIAL_CONTROL, t2ub_pkg::OFS_BAUD_RELOAD, t2ub_pkg::OFS_BAUD_CONTROL,
            t2ub_pkg::OFS_SLAVE_ADDRESS, t2ub_pkg::OFS_SLAVE_MASK, t2ub_pkg::OFS_TIMER2_CONTROL};
        foreach (a[i]) xfer(1'h1, a[i], 32'h1C);
        rdchk("mid-run write", t2ub_pkg::OFS_SLAVE_ADDRESS, 32'h1C);
        rst_n <= 1'h0;
        repeat (2) @(posedge clock);
        rst_n <= 1'h1;
        @(posedge clock);
        foreach (a[i]) rdchk("mid-run reset", a[i], 32'h0);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clock);
        rst_n <= 1'h1;
        @(posedge clock);
        t_regs();
        t_ovf();
        t_sel();
        t_ext();
        t_cnt();
        t_brg();
        t_rst();
        print_verdict();
    end
    // whole run needs about 1300 cycles
    initial
    begin
        repeat (20000) @(posedge clock);
        mismatches++;
        $display("ERROR watchdog expected finish seen timeout");
        print_verdict();
    end
endmodule // t2ub_top_tb_top
